/* File: design/isc_pkg.sv */
// constants and types for the i2c sequence control block
package isc_pkg;

	// timing: one quarter of an scl period at 100 kHz
	localparam int CLK_NS  = 40;
	localparam int QTR_NS  = 2500;
	localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;

	// apb byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_OWN  = 8'h08;
	localparam logic [7:0] A_IST  = 8'h0c;
	localparam logic [7:0] A_ICLR = 8'h10;
	localparam logic [7:0] A_IEN  = 8'h14;

	// bus_control_one bit positions
	localparam int B_START = 0;
	localparam int B_RS    = 1;
	localparam int B_STOP  = 2;
	localparam int B_RCV   = 3;
	localparam int B_ACK   = 4;
	localparam int B_ACK_VALUE = 5;
	localparam int B_CLOCK_STRETCH_ENABLE = 6;
	localparam int B_GENERAL_CALL_ENABLE  = 7;
	localparam int B_REL   = 8;
	localparam int B_ADDRESS_HOLD_ENABLE  = 9;
	localparam int B_DATA_HOLD_ENABLE  = 10;

	// interrupt event bit positions
	localparam int EV_MDONE = 0;
	localparam int EV_MRX   = 1;
	localparam int EV_SADR  = 2;
	localparam int EV_SRX   = 3;

	// reset values and fixed codes
	localparam logic [10:0] CTRL_RST = 11'h000;
	localparam logic [6:0]  OWN_RST  = 7'h50;
	localparam logic [7:0]  GC_ADDR  = 8'h00;

	// master sequence states
	typedef enum logic [5:0] {
		M_IDLE  = 6'b000001,
		M_START = 6'b000010,
		M_RSTRT = 6'b000100,
		M_STOP  = 6'b001000,
		M_ACK   = 6'b010000,
		M_RECV  = 6'b100000
	} isc_msm_t;

	// slave receive states
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_ADDR = 6'b000010,
		S_AACK = 6'b000100,
		S_DATA = 6'b001000,
		S_DACK = 6'b010000,
		S_HOLD = 6'b100000
	} isc_ssm_t;

endpackage

/* File: design/isc_top.sv */
// i2c sequence control: master sequences, slave match, apb registers
`timescale 1ns/100ps
`default_nettype none
module isc_top
	import isc_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst_b,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_irq,
	input  wire logic        i_scl,
	output logic             o_scl_o,
	output logic             o_scl_oe_b,
	input  wire logic        i_sda,
	output logic             o_sda_o,
	output logic             o_sda_oe_b
);

	typedef struct packed {
		logic [10:0] ctrl;
		logic [6:0]  own;
		logic [3:0]  ist;
		logic [3:0]  ien;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic [1:0]  scl_s;
		logic [1:0]  sda_s;
		logic        scl_p;
		logic        sda_p;
		logic [5:0]  div;
		logic        tick;
		isc_msm_t    mst;
		logic [1:0]  ph;
		logic [2:0]  bitn;
		logic [7:0]  mrx;
		logic        mscl;
		logic        msda;
		isc_ssm_t    sst;
		logic [3:0]  scnt;
		logic [7:0]  ssh;
		logic [7:0]  srx;
		logic        gc;
		logic        rd;
		logic        sscl;
		logic        ssda;
		logic        scl_oe_b;
		logic        sda_oe_b;
	} isc_state_t;

	isc_state_t q;
	isc_state_t d;

	logic setup;
	logic acc;
	logic wr_ctrl;
	logic sfall;
	logic srise;
	logic s_start;
	logic s_stop;
	logic gc_hit;
	logic own_hit;
	logic ack_low;
	logic madv;

	// bus phase decode
	assign setup   = i_psel & ~i_penable;
	assign acc     = i_psel & i_penable & q.pready;
	assign wr_ctrl = acc & i_pwrite & (i_paddr == A_CTRL);

	// line events from synchronised pins
	assign sfall   = q.scl_p & ~q.scl_s[1];
	assign srise   = ~q.scl_p & q.scl_s[1];
	assign s_start = q.sda_p & ~q.sda_s[1] & q.scl_s[1];
	assign s_stop  = ~q.sda_p & q.sda_s[1] & q.scl_s[1];

	// slave address match
	assign gc_hit  = q.ctrl[B_GENERAL_CALL_ENABLE] & (q.ssh == GC_ADDR);
	assign own_hit = (q.ssh[7:1] == q.own) & (q.ssh[7:1] != 7'h00);
	assign ack_low = (q.ctrl[B_ADDRESS_HOLD_ENABLE] | q.ctrl[B_DATA_HOLD_ENABLE]) ?
		~q.ctrl[B_ACK_VALUE] : 1'b1;

	// master waits while its released scl is held low
	assign madv = q.tick & (q.mscl | q.scl_s[1]);

	// next-state logic for the whole block
	always_comb begin
		logic [3:0] ev;
		logic [3:0] clr;
		ev  = 4'h0;
		clr = 4'h0;
		d   = q;
		d.scl_s = {q.scl_s[0], i_scl};
		d.sda_s = {q.sda_s[0], i_sda};
		d.scl_p = q.scl_s[1];
		d.sda_p = q.sda_s[1];

		// quarter-bit divider, runs only during a sequence
		d.tick = 1'b0;
		if (q.mst == M_IDLE) begin
			d.div = 6'h00;
		end else if (q.div == 6'(QTR_CYC - 1)) begin
			d.div  = 6'h00;
			d.tick = 1'b1;
		end else begin
			d.div = q.div + 6'h01;
		end

		// master sequence engine
		unique case (q.mst)
			M_IDLE: begin
				d.ph   = 2'd0;
				d.bitn = 3'd0;
				if (q.ctrl[B_START]) begin
					d.mst = M_START;
				end else if (q.ctrl[B_RS]) begin
					d.mst = M_RSTRT;
				end else if (q.ctrl[B_STOP]) begin
					d.mst = M_STOP;
				end else if (q.ctrl[B_ACK]) begin
					d.mst = M_ACK;
				end else if (q.ctrl[B_RCV]) begin
					d.mst = M_RECV;
				end
			end
			M_START: if (madv) begin
				d.ph = q.ph + 2'd1;
				if (q.ph == 2'd0) begin
					d.msda = 1'b0;
					d.mscl = 1'b0;
				end
				if (q.ph == 2'd1) d.msda = 1'b1;  // sda falls, scl high
				if (q.ph == 2'd2) d.mscl = 1'b1;
				if (q.ph == 2'd3) begin
					d.ctrl[B_START] = 1'b0;
					d.mst = M_IDLE;
					ev[EV_MDONE] = 1'b1;
				end
			end
			M_RSTRT: if (madv) begin
				d.ph = q.ph + 2'd1;
				if (q.ph == 2'd0) d.msda = 1'b0;
				if (q.ph == 2'd1) d.mscl = 1'b0;
				if (q.ph == 2'd2) d.msda = 1'b1;
				if (q.ph == 2'd3) begin
					d.mscl = 1'b1;
					d.ctrl[B_RS] = 1'b0;
					d.mst = M_IDLE;
					ev[EV_MDONE] = 1'b1;
				end
			end
			M_STOP: if (madv) begin
				d.ph = q.ph + 2'd1;
				if (q.ph == 2'd0) d.msda = 1'b1;
				if (q.ph == 2'd1) d.mscl = 1'b0;
				if (q.ph == 2'd2) d.msda = 1'b0;  // sda rises, scl high
				if (q.ph == 2'd3) begin
					d.ctrl[B_STOP] = 1'b0;
					d.mst = M_IDLE;
					ev[EV_MDONE] = 1'b1;
				end
			end
			M_ACK: if (madv) begin
				d.ph = q.ph + 2'd1;
				if (q.ph == 2'd0) d.msda = ~q.ctrl[B_ACK_VALUE];
				if (q.ph == 2'd1) d.mscl = 1'b0;
				if (q.ph == 2'd2) d.mscl = 1'b1;
				if (q.ph == 2'd3) begin
					d.msda = 1'b0;
					d.ctrl[B_ACK] = 1'b0;
					d.mst = M_IDLE;
					ev[EV_MDONE] = 1'b1;
				end
			end
			M_RECV: if (madv) begin
				d.ph = q.ph + 2'd1;
				if (q.ph == 2'd0) d.msda = 1'b0;
				if (q.ph == 2'd1) d.mscl = 1'b0;
				if (q.ph == 2'd2) d.mrx = {q.mrx[6:0], q.sda_s[1]};
				if (q.ph == 2'd3) begin
					d.mscl = 1'b1;
					d.bitn = q.bitn + 3'd1;
					if (q.bitn == 3'd7) begin
						d.ctrl[B_RCV] = 1'b0;
						d.mst = M_IDLE;
						ev[EV_MRX] = 1'b1;
					end
				end
			end
		endcase

		// slave receiver, bus start and stop take priority
		if (s_stop) begin
			d.sst  = S_IDLE;
			d.ssda = 1'b0;
			d.sscl = 1'b0;
		end else if (s_start) begin
			d.sst  = S_ADDR;
			d.scnt = 4'd0;
			d.ssda = 1'b0;
			d.sscl = 1'b0;
			d.gc   = 1'b0;
			d.rd   = 1'b0;
		end else begin
			unique case (q.sst)
				S_IDLE: begin
				end
				S_ADDR, S_DATA: begin
					if (srise) begin
						d.ssh  = {q.ssh[6:0], q.sda_s[1]};
						d.scnt = q.scnt + 4'd1;
					end else if (sfall && q.scnt == 4'd8) begin
						if (q.sst == S_DATA) begin
							d.srx  = q.ssh;
							d.ssda = ack_low;
							d.ctrl[B_REL] = 1'b0;
							d.sst  = S_DACK;
							ev[EV_SRX] = 1'b1;
						end else if (gc_hit | own_hit) begin
							d.gc   = gc_hit;
							d.rd   = q.ssh[0];
							d.ssda = ack_low;
							d.sst  = S_AACK;
							ev[EV_SADR] = 1'b1;
							if (q.ssh[0]) begin
								d.ctrl[B_REL]   = 1'b0;
								d.ctrl[B_CLOCK_STRETCH_ENABLE] = 1'b0;
							end
						end else begin
							d.sst = S_IDLE;
						end
					end
				end
				S_AACK, S_DACK: if (sfall) begin
					d.ssda = 1'b0;
					d.scnt = 4'd0;
					if (q.rd) begin
						d.sst = S_IDLE;
					end else if (q.ctrl[B_CLOCK_STRETCH_ENABLE] & ~q.ctrl[B_REL]) begin
						d.sscl = 1'b1;
						d.sst  = S_HOLD;
					end else begin
						d.sst = S_DATA;
					end
				end
				S_HOLD: if (q.ctrl[B_REL]) begin
					d.sscl = 1'b0;
					d.sst  = S_DATA;
				end
			endcase
		end

		// apb: answer in the first access cycle
		d.pready  = setup;
		d.pslverr = 1'b0;
		d.prdata  = 32'h0000_0000;
		if (setup) begin
			unique case (i_paddr)
				A_CTRL: d.prdata = {21'h0, q.ctrl};
				A_STAT: d.prdata = {12'h0, q.rd, q.gc, q.sst != S_IDLE,
					q.mst != M_IDLE, q.srx, q.mrx};
				A_OWN:  d.prdata = {25'h0, q.own};
				A_IST:  d.prdata = {28'h0, q.ist};
				A_ICLR: d.prdata = 32'h0000_0000;
				A_IEN:  d.prdata = {28'h0, q.ien};
				default: d.pslverr = 1'b1;
			endcase
		end
		if (acc && i_pwrite && !q.pslverr) begin
			unique case (i_paddr)
				A_CTRL: begin
					d.ctrl[B_DATA_HOLD_ENABLE:B_ACK_VALUE] = i_pwdata[B_DATA_HOLD_ENABLE:B_ACK_VALUE];
					if (q.mst == M_IDLE && q.ctrl[B_ACK:B_START] == 5'h00)
						d.ctrl[B_ACK:B_START] = i_pwdata[B_ACK:B_START];
				end
				A_OWN:  d.own = i_pwdata[6:0];
				A_ICLR: clr = i_pwdata[3:0];
				A_IEN:  d.ien = i_pwdata[3:0];
				default: begin
				end
			endcase
		end

		// sticky events, a new event beats a clear
		d.ist = (q.ist & ~clr) | ev;
		d.irq = |(d.ist & d.ien);
		d.scl_oe_b = ~(d.mscl | d.sscl);
		d.sda_oe_b = ~(d.msda | d.ssda);
	end

	// state register
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			q          <= '0;
			q.ctrl     <= CTRL_RST;
			q.own      <= OWN_RST;
			q.mst      <= M_IDLE;
			q.sst      <= S_IDLE;
			q.scl_oe_b <= 1'b1;
			q.sda_oe_b <= 1'b1;
			// idle bus level, so no false edge follows reset
			q.scl_s    <= 2'b11;
			q.sda_s    <= 2'b11;
			q.scl_p    <= 1'b1;
			q.sda_p    <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register, except o_scl_o and o_sda_o tied low
	assign o_prdata   = q.prdata;
	assign o_pready   = q.pready;
	assign o_pslverr  = q.pslverr;
	assign o_irq      = q.irq;
	assign o_scl_o    = 1'b0;
	assign o_sda_o    = 1'b0;
	assign o_scl_oe_b = q.scl_oe_b;
	assign o_sda_oe_b = q.sda_oe_b;

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	property p_gc_off;
		sfall && q.sst == S_ADDR && q.scnt == 4'd8 && q.ssh == GC_ADDR
		&& !q.ctrl[B_GENERAL_CALL_ENABLE] && !s_start && !s_stop |=> q.sst == S_IDLE;
	endproperty
	a_gc_off: assert property (p_gc_off) else $error("gc accepted");

	property p_gc_on;
		sfall && q.sst == S_ADDR && q.scnt == 4'd8 && q.ssh == GC_ADDR
		&& q.ctrl[B_GENERAL_CALL_ENABLE] && !s_start && !s_stop
		|=> q.sst == S_AACK && q.gc && q.ist[EV_SADR];
	endproperty
	a_gc_on: assert property (p_gc_on) else $error("gc missed");

	property p_hold;
		q.sst != S_HOLD ##1 q.sst == S_HOLD |-> $past(q.ctrl[B_CLOCK_STRETCH_ENABLE], 1);
	endproperty
	a_hold: assert property (p_hold) else $error("stretch off");

	property p_mack;
		q.mst == M_ACK && q.ph == 2'd2 |-> q.msda == ~q.ctrl[B_ACK_VALUE];
	endproperty
	a_mack: assert property (p_mack) else $error("ack level");

	property p_sack;
		q.sst == S_DACK && (q.ctrl[B_ADDRESS_HOLD_ENABLE] | q.ctrl[B_DATA_HOLD_ENABLE])
		&& $stable(q.ctrl) |-> q.ssda == ~q.ctrl[B_ACK_VALUE];
	endproperty
	a_sack: assert property (p_sack) else $error("slave ack");

	property p_rcv;
		$fell(q.ctrl[B_RCV]) |-> $past(q.mst, 1) == M_RECV
		&& $past(q.bitn, 1) == 3'd7;
	endproperty
	a_rcv: assert property (p_rcv) else $error("rcv clear");

	property p_stop;
		q.mst == M_STOP |-> q.ctrl[B_STOP];
	endproperty
	a_stop: assert property (p_stop) else $error("stop bit");

	property p_rs;
		q.mst == M_RSTRT |-> q.ctrl[B_RS];
	endproperty
	a_rs: assert property (p_rs) else $error("restart bit");

	property p_start;
		q.mst == M_START && q.ph == 2'd3 |-> q.mscl && q.msda;
	endproperty
	a_start: assert property (p_start) else $error("start lines");

	property p_done;
		$fell(q.ctrl[B_START]) |-> q.mst == M_IDLE && q.ist[EV_MDONE];
	endproperty
	a_done: assert property (p_done) else $error("start done");

	property p_rel;
		sfall && q.sst == S_DATA && q.scnt == 4'd8 && !s_start && !s_stop
		&& !wr_ctrl |=> !q.ctrl[B_REL] && q.ist[EV_SRX];
	endproperty
	a_rel: assert property (p_rel) else $error("release kept");

	c_start: cover property (q.mst == M_START ##1 q.mst == M_IDLE);
	c_recv:  cover property ($fell(q.ctrl[B_RCV]));
	c_gc:    cover property (q.gc && q.sst == S_AACK);
	c_hold:  cover property (q.sst == S_HOLD ##1 q.sst == S_DATA);

endmodule
`default_nettype wire

/* File: verif/isc_far_dev.sv */
// far-side i2c device: byte source and address-phase master
`timescale 1ns/100ps
`default_nettype none
module isc_far_dev (
	input  wire logic i_mclk,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_scl_low,
	output logic      o_sda_low
);
	logic [7:0] tx_b;
	int         tx_n;
	logic       tx_on;

	// lines released at start
	initial begin
		o_scl_low = 0;
		o_sda_low = 0;
		tx_on = 0;
		tx_n = 0;
		tx_b = 0;
	end

	// next bit after each scl fall, msb first, released after eight
	always @(negedge i_scl) begin
		if (tx_on) begin
			tx_n = tx_n + 1;
			tx_on <= (tx_n < 8);
			o_sda_low <= (tx_n < 8) & ~tx_b[7 - tx_n];
		end
	end

	// load a byte for the master to clock in
	task automatic arm(input logic [7:0] b);
		tx_b = b;
		tx_n = 0;
		tx_on <= 1;
		o_sda_low <= ~b[7];
	endtask

	// half link period, waiting out a stretched scl
	task automatic half();
		int n;
		n = 0;
		repeat (4) @(posedge i_mclk);
		while (i_scl !== 1'b1 && !o_scl_low && n < 400) begin
			@(posedge i_mclk);
			n++;
		end
	endtask

	// start condition, then the address byte
	task automatic xfer(input logic [7:0] a, output logic ack);
		o_sda_low <= 1;
		half();
		o_scl_low <= 1;
		put(a, ack);
	endtask

	// one byte msb first, ninth clock with ack sampled
	task automatic put(input logic [7:0] a, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			o_sda_low <= ~a[i];
			half();
			o_scl_low <= 0;
			half();
			o_scl_low <= 1;
		end
		o_sda_low <= 0;
		half();
		o_scl_low <= 0;
		half();
		ack = i_sda;
		o_scl_low <= 1;
	endtask

	// stop condition
	task automatic stop_c();
		o_sda_low <= 1;
		half();
		o_scl_low <= 0;
		half();
		o_sda_low <= 0;
		half();
	endtask
endmodule
`default_nettype wire

/* File: verif/tb_i2c_sequence_control.sv */
// self-checking bench for the i2c sequence control block
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_sequence_control;
	import isc_pkg::*;
	logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic        pready, pslverr, irq, scl_o, scl_oe_b, sda_o, sda_oe_b;
	logic        f_scl, f_sda, e, ack;
	logic        last_bit = 1;
	int          err_total = 0, compares = 0, cyc = 0;
	int          n_start = 0, n_stop = 0;
	// open-drain wires with pull-ups
	wire         scl_w = (scl_oe_b | scl_o) & ~f_scl;
	wire         sda_w = (sda_oe_b | sda_o) & ~f_sda;

	always #20 clk = ~clk;

	isc_top u_dut (.i_mclk(clk), .i_rst_b(rst_b), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_irq(irq), .i_scl(scl_w), .o_scl_o(scl_o),
		.o_scl_oe_b(scl_oe_b), .i_sda(sda_w), .o_sda_o(sda_o),
		.o_sda_oe_b(sda_oe_b));
	isc_far_dev u_far (.i_mclk(clk), .i_scl(scl_w), .i_sda(sda_w),
		.o_scl_low(f_scl), .o_sda_low(f_sda));

	// line monitor: start, stop and level at each scl rise
	always @(negedge sda_w) if (scl_w) n_start++;
	always @(posedge sda_w) if (scl_w) n_stop++;
	always @(posedge scl_w) last_bit = sda_w;

	task automatic end_of_test();
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(0, a, 0);
		chk(r, exp);
	endtask

	// poll ctrl until the request bits read zero
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(0, A_CTRL, 0);
			n++;
		end while (r[4:0] !== 5'h00 && n < 1500);
		chk({27'h0, r[4:0]}, 0);
	endtask

	task automatic t_reset();
		rd(A_CTRL, {21'h0, CTRL_RST});
		rd(A_OWN, {25'h0, OWN_RST});
		rd(A_IST, 0);
		apb(0, 8'h3c, 0);
		chk(e, 1);
		chk(r, 0);
		$display("reset test done");
	endtask

	task automatic t_start();
		int s;
		s = n_start;
		wr(A_IEN, 32'h3);
		wr(A_CTRL, 32'h1 << B_START);
		wait_idle();
		chk(n_start, s + 1);
		chk(irq, 1);
		rd(A_IST, 32'h1 << EV_MDONE);
		wr(A_IEN, 0);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		wr(A_IEN, 32'h3);
		wr(A_ICLR, 32'hf);
		repeat (2) @(posedge clk);
		chk(irq, 0);
	endtask

	task automatic t_recv(input logic [7:0] b, input logic ackv);
		u_far.arm(b);
		wr(A_CTRL, 32'h1 << B_RCV);
		wait_idle();
		apb(0, A_STAT, 0);
		chk(r[7:0], b);
		wr(A_CTRL, (32'h1 << B_ACK) | (ackv << B_ACK_VALUE));
		wait_idle();
		chk(last_bit, ackv);
	endtask

	task automatic t_master();
		int s;
		t_start();
		t_recv(8'ha5, 1);
		s = n_start;
		wr(A_CTRL, 32'h1 << B_RS);
		wait_idle();
		chk(n_start, s + 1);
		t_recv(8'h3c, 0);
		s = n_stop;
		wr(A_CTRL, 32'h1 << B_STOP);
		wait_idle();
		chk(n_stop, s + 1);
		$display("master test done");
	endtask

	task automatic t_slave(input logic [31:0] c, input logic [7:0] a,
		input logic exp);
		wr(A_CTRL, c);
		u_far.xfer(a, ack);
		chk(ack, exp);
		u_far.stop_c();
	endtask

	task automatic t_stretch();
		wr(A_CTRL, (32'h1 << B_GENERAL_CALL_ENABLE) | (32'h1 << B_CLOCK_STRETCH_ENABLE));
		u_far.xfer(8'h00, ack);
		chk(ack, 0);
		fork
			u_far.put(8'h5a, ack);
			begin
				repeat (20) @(posedge clk);
				chk(scl_w, 0);
				wr(A_CTRL, 32'h1 << B_REL);
			end
		join
		chk(ack, 0);
		rd(A_CTRL, 0);
		rd(A_STAT, 32'h0006_5a3c);
		u_far.stop_c();
		chk(scl_w, 1);
		$display("stretch test done");
	endtask

	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1;
		t_reset();
		t_master();
		wr(A_ICLR, 32'hf);
		t_slave(32'h1 << B_GENERAL_CALL_ENABLE, 8'h00, 0);
		apb(0, A_IST, 0);
		chk(r[EV_SADR], 1);
		t_slave(0, 8'h00, 1);
		t_slave((32'h1 << B_ADDRESS_HOLD_ENABLE) | (32'h1 << B_ACK_VALUE), 8'ha0, 1);
		t_slave(32'h1 << B_DATA_HOLD_ENABLE, 8'ha0, 0);
		t_slave((32'h1 << B_CLOCK_STRETCH_ENABLE) | (32'h1 << B_REL), 8'ha1, 0);
		rd(A_CTRL, 0);
		$display("slave test done");
		t_stretch();
		end_of_test();
	end
endmodule
`default_nettype wire
